// ==== core/arss_pkg.sv ====
// Package for the auxiliary rail soft start shaper: register map, fields, timing.
// Assumes a 100 MHz device clock and an 8-bit register port.
package arss_pkg;
   localparam logic [15:0] ARSS_CFG_OFFSET   = 16'hfe68;
   localparam logic [15:0] ARSS_STAT_OFFSET  = 16'hfe6b;
   localparam logic [7:0]  ARSS_CFG_RESET    = 8'h00;
   localparam int          ARSS_B_EDGE_A     = 7;
   localparam int          ARSS_B_EDGE_B     = 6;
   localparam int          ARSS_B_RATE_HI    = 5;
   localparam int          ARSS_B_RATE_LO    = 4;
   localparam int          ARSS_B_GLOBAL     = 3;
   localparam int          ARSS_B_VAR2       = 2;
   localparam int          ARSS_B_SEL_ODD    = 1;
   localparam int          ARSS_B_SEL_EVEN   = 0;
   localparam int          ARSS_CLK_NS       = 10;
   localparam int          ARSS_STEP_NS      = 40;
   localparam int          ARSS_STEP_CYC     = ARSS_STEP_NS / ARSS_CLK_NS;
   localparam int          ARSS_TW           = 16;

   typedef struct packed {
      logic       edge_a;
      logic       edge_b;
      logic [1:0] rate;
      logic       global_var;
      logic       var2_mode;
      logic       sel_odd;
      logic       sel_even;
   } arss_cfg_t;

   typedef struct packed {
      logic [ARSS_TW-1:0] rise;
      logic [ARSS_TW-1:0] fall;
   } arss_edge_t;
endpackage : arss_pkg

// ==== core/arss_step_timer.sv ====
// Switching-cycle counter that issues one ramp step per selected number of cycles.
// Assumes cycle_start is a one-clock pulse per switching cycle.
`timescale 1ns/1ns
`default_nettype none
module arss_step_timer
   import arss_pkg::*;
(
   input  wire logic       i_clk,         // Device clock.
   input  wire logic       i_rst_b,       // Async reset, active low.
   input  wire logic       i_clear,       // Restart count at soft start begin.
   input  wire logic       i_cycle_start, // Switching cycle start pulse.
   input  wire logic [1:0] i_rate,        // Ramp rate code.
   output logic            o_step         // One-clock step pulse.
);
   logic [2:0] cnt_r;
   logic [2:0] limit;

   always_comb begin
      limit = 3'(({2'h0, 1'b1} << i_rate) - 3'h1);
      if (i_rate == 2'h3) begin
         limit = 3'h7;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_r  <= 3'h0;
         o_step <= 1'b0;
      end else if (i_clear) begin
         cnt_r  <= 3'h0;
         o_step <= 1'b0;
      end else if (i_cycle_start) begin
         o_step <= (cnt_r >= limit);
         cnt_r  <= (cnt_r >= limit) ? 3'h0 : cnt_r + 3'h1;
      end else begin
         o_step <= 1'b0;
      end
   end
endmodule : arss_step_timer
`default_nettype wire

// ==== core/arss_shaper.sv ====
// Soft start shaper for the eight drive lines of the fixed-duty auxiliary rail.
// Assumes target edge times per line and a cycle-start pulse from the PWM timebase.
// Assumes targets are held steady by the timebase and that each rises before it falls.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Edge-order A set: lines 1,2,5,6 fall after rising each cycle in soft start.
// - Edge-order B acts only while edge-order A is one.
// - B=0: lines 3,4,7,8 rise after falling; B=1: fall after rising.
// - Step 40 ns every 1, 2, 4 or 8 cycles per rate field.
// - Global bit 0: odd and even groups vary apart; 1: all follow line 2.
// - Odd/even source selects are ignored when global bit is one.
// - Line 2 variation is fall minus rise, or period minus rise.
module arss_shaper
   import arss_pkg::*;
#(
   parameter int TW = ARSS_TW
)(
   input  wire logic                i_clk,         // Device clock.
   input  wire logic                i_rst_b,       // Async reset, active low.
   input  wire logic [15:0]         i_addr,        // Register address.
   input  wire logic [7:0]          i_wdata,       // Write data.
   input  wire logic                i_wr,          // Write strobe.
   input  wire logic                i_rd,          // Read strobe.
   output logic      [7:0]          o_rdata,       // Read data, cycle after strobe.
   input  wire logic                i_ss_start,    // Soft start begin pulse.
   input  wire logic                i_ss_active,   // Soft start in progress.
   input  wire logic                i_cycle_start, // Switching cycle start pulse.
   input  wire logic [TW-1:0]       i_period,      // Switching period in clocks.
   input  wire arss_pkg::arss_edge_t i_tgt [8],    // Final edges per line.
   output arss_pkg::arss_edge_t     o_edge [8],    // Shaped edges per line.
   output logic      [TW-1:0]       o_var_odd,     // Variation applied to odd lines.
   output logic      [TW-1:0]       o_var_even     // Variation applied to even lines.
);
   import arss_pkg::*;

   // Configuration register and ramp state.
   arss_cfg_t     cfg_r;
   logic          cfg_wr;
   logic [TW-1:0] ramp_r;
   logic          ramp_go;
   logic          step;
   logic          cyc_live;
   // Per-line on time and group variation.
   logic [TW-1:0] span [8];
   logic [TW-1:0] var2;
   logic [TW-1:0] v_odd;
   logic [TW-1:0] v_even;
   logic [TW-1:0] lim_odd;
   logic [TW-1:0] lim_even;
   logic          edge_b_eff;
   // Register read path.
   logic [7:0]    rdata_nxt;

   // Writes to any other offset are dropped; the status byte is read-only.
   assign cfg_wr = i_wr && (i_addr == ARSS_CFG_OFFSET);

   // The whole byte is kept, including the source selects that global mode ignores.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_r <= arss_cfg_t'(ARSS_CFG_RESET);
      end else if (cfg_wr) begin
         cfg_r <= arss_cfg_t'(i_wdata);
      end
   end

   // Read data are decoded here and registered below, so the port shows them
   // for exactly one cycle after the strobe and zero in every other cycle.
   always_comb begin
      rdata_nxt = 8'h00;
      if (i_rd) begin
         case (i_addr)
            ARSS_CFG_OFFSET: begin
               rdata_nxt = 8'(cfg_r);
            end
            ARSS_STAT_OFFSET: begin
               rdata_nxt = {7'h00, i_ss_active};
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end

   // Only switching cycles inside soft start advance the ramp.
   assign cyc_live = i_cycle_start & i_ss_active;

   // The cycle counter is cleared at every soft start begin.
   arss_step_timer u_timer (
      .i_clk         (i_clk),
      .i_rst_b       (i_rst_b),
      .i_clear       (i_ss_start),
      .i_cycle_start (cyc_live),
      .i_rate        (cfg_r.rate),
      .o_step        (step)
   );

   // A step is taken only while the ramp is still below one full period.
   assign ramp_go = step && (ramp_r < i_period);

   // Ramp grows one step of clocks per selected cycle count. It stops at the
   // period, so a variation can never ask for more than a whole cycle; the
   // last step may overshoot the period by less than one step.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ramp_r <= '0;
      end else if (i_ss_start) begin
         ramp_r <= '0;
      end else if (ramp_go) begin
         ramp_r <= ramp_r + TW'(ARSS_STEP_CYC);
      end
   end

   // On time of each line as targeted. A target that falls before it rises
   // would wrap here; the timebase is expected never to hand one over.
   generate
      for (genvar g = 0; g < 8; g++) begin : g_span
         assign span[g] = i_tgt[g].fall - i_tgt[g].rise;
      end
   endgenerate

   // Line 2 variation: on time as programmed, or the rest of the period after
   // its rising edge.
   always_comb begin
      if (cfg_r.var2_mode) begin
         var2 = i_period - i_tgt[1].rise;
      end else begin
         var2 = span[1];
      end
   end

   // Group B order is only honoured while group A order is enabled.
   assign edge_b_eff = cfg_r.edge_a & cfg_r.edge_b;

   // Source of each group's limit. In global mode the odd and even source
   // selects are not looked at at all.
   always_comb begin
      if (cfg_r.global_var) begin
         lim_odd  = var2;
         lim_even = var2;
      end else begin
         if (cfg_r.sel_odd) begin
            lim_odd = span[2];
         end else begin
            lim_odd = span[0];
         end
         if (cfg_r.sel_even) begin
            lim_even = span[3];
         end else begin
            lim_even = var2;
         end
      end
   end

   // The applied variation follows the ramp and never passes its limit, so a
   // long ramp settles each group exactly at its selected limit (lim_odd or lim_even).
   always_comb begin
      if (ramp_r < lim_odd) begin
         v_odd = ramp_r;
      end else begin
         v_odd = lim_odd;
      end
      if (ramp_r < lim_even) begin
         v_even = ramp_r;
      end else begin
         v_even = lim_even;
      end
   end

   // Lines in groups A/B keep the chosen edge fixed and move the other edge.
   // Edges are registered, so a target change shows up one clock later.
   generate
      for (genvar g = 0; g < 8; g++) begin : g_line
         localparam bit GRP_A = (g == 0 || g == 1 || g == 4 || g == 5);
         localparam bit ODD   = (g % 2 == 0);
         logic [TW-1:0] v_line;
         assign v_line = ODD ? v_odd : v_even;
         always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               o_edge[g] <= '0;
            end else if (!i_ss_active) begin
               // Outside soft start a line just follows its targets.
               o_edge[g] <= i_tgt[g];
            end else if (GRP_A ? cfg_r.edge_a : edge_b_eff) begin
               // Rising edge stays on target; the falling edge trails it.
               o_edge[g].rise <= i_tgt[g].rise;
               o_edge[g].fall <= i_tgt[g].rise + v_line;
            end else begin
               o_edge[g].fall <= i_tgt[g].fall;
               o_edge[g].rise <= i_tgt[g].fall - v_line;
            end
         end
      end
   endgenerate

   // Variation outputs are registered so that they line up with o_edge.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_var_odd <= '0;
      end else begin
         o_var_odd <= v_odd;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_var_even <= '0;
      end else begin
         o_var_even <= v_even;
      end
   end
endmodule : arss_shaper
`default_nettype wire

// ==== dv/arss_checker.sv ====
// Checker bound to the shaper: read port, variation limits, ramp step, edge order.
// Assumes the config register changes only by writes at its offset.
`timescale 1ns/1ns
`default_nettype none
module arss_checker
   import arss_pkg::*;
#(parameter int TW = ARSS_TW)(
   input wire logic          i_clk,
   input wire logic          i_rst_b,
   input wire logic [15:0]   i_addr,
   input wire logic [7:0]    i_wdata,
   input wire logic          i_wr,
   input wire logic          i_rd,
   input wire logic [7:0]    o_rdata,
   input wire logic          i_ss_active,
   input wire logic [TW-1:0] i_period,
   input wire arss_pkg::arss_edge_t i_tgt [8],
   input wire arss_pkg::arss_edge_t o_edge [8],
   input wire logic [TW-1:0] o_var_odd,
   input wire logic [TW-1:0] o_var_even
);
   arss_cfg_t  cfg;
   logic [1:0] quiet;
   wire        ok = i_ss_active && quiet == 2'h3;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) cfg <= arss_cfg_t'(8'h00);
      else if (i_wr && i_addr == ARSS_CFG_OFFSET) cfg <= arss_cfg_t'(i_wdata);
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) quiet <= 2'h0;
      else if (i_wr) quiet <= 2'h0;
      else if (quiet != 2'h3) quiet <= quiet + 2'h1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_rd_cfg;
      i_rd && i_addr == ARSS_CFG_OFFSET;
   endsequence
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside slot");
   a_cfg_read: assert property (s_rd_cfg |=> o_rdata == $past(cfg))
      else $error("config read wrong");
   a_global_same: assert property (ok && cfg.global_var |-> o_var_odd == o_var_even)
      else $error("global variation differs");
   a_odd_limit: assert property (ok && !cfg.global_var && !cfg.sel_odd
      |-> o_var_odd <= i_tgt[0].fall - i_tgt[0].rise) else $error("odd limit");
   a_even_span: assert property (ok && !cfg.var2_mode && (cfg.global_var || !cfg.sel_even)
      |-> o_var_even <= i_tgt[1].fall - i_tgt[1].rise) else $error("span limit");
   a_even_period: assert property (ok && cfg.var2_mode && (cfg.global_var || !cfg.sel_even)
      |-> o_var_even <= i_period - i_tgt[1].rise) else $error("period limit");
   a_step_size: assert property (ok && $past(ok) |-> o_var_even <= $past(o_var_even) + 16'h4)
      else $error("step too large");
   a_edge_a: assert property (ok && cfg.edge_a |-> o_edge[0].fall >= o_edge[0].rise
      && o_edge[5].fall >= o_edge[5].rise) else $error("group A order");
   a_edge_b: assert property (ok && cfg.edge_a && cfg.edge_b
      |-> o_edge[2].fall >= o_edge[2].rise) else $error("group B order");
endmodule : arss_checker
bind arss_shaper arss_checker #(.TW(TW)) u_chk (.*);
`default_nettype wire

// ==== dv/arss_stage_model.sv ====
// Switching timebase beside the power stage: one cycle-start pulse per period.
// Assumes a period of at least two clocks.
`timescale 1ns/1ns
`default_nettype none
module arss_stage_model (
   input  wire logic        i_clk,         // Device clock.
   input  wire logic        i_rst_b,       // Async reset, active low.
   input  wire logic [15:0] i_period,      // Period in clocks.
   output logic             o_cycle_start  // Start pulse.
);
   logic [15:0] cnt_r;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) cnt_r <= 16'h0000;
      else cnt_r <= (cnt_r + 16'h1 >= i_period) ? 16'h0000 : cnt_r + 16'h1;
   end
   assign o_cycle_start = i_rst_b && cnt_r == 16'h0000;
endmodule : arss_stage_model
`default_nettype wire

// ==== dv/arss_tb.sv ====
// Self-checking bench for the soft start shaper.
// Assumes the stage model paces switching cycles at PER clocks.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import arss_pkg::*;
   localparam logic [15:0] PER = 16'h0040;
   logic        i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_cycle_start;
   logic        i_ss_start = 1'b0, i_ss_active = 1'b0;
   logic [15:0] i_addr = 16'h0000, i_period = PER, o_var_odd, o_var_even;
   logic [7:0]  i_wdata = 8'h00, o_rdata;
   arss_edge_t  i_tgt [8], o_edge [8];
   int          fail_count = 0, compares = 0, n;
   arss_shaper uut (.*);
   arss_stage_model stage (.i_clk, .i_rst_b, .i_period, .o_cycle_start(i_cycle_start));
   always #5 i_clk = ~i_clk;
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
      @(posedge i_clk) i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      i_addr <= a; i_rd <= 1'b1;
      @(posedge i_clk) i_rd <= 1'b0;
      #1 chk(16'(o_rdata), 16'(x));
      @(posedge i_clk);
   endtask : rd
   task automatic start(input logic [7:0] c);
      @(posedge i_clk) wr(ARSS_CFG_OFFSET, c);
      i_ss_start <= 1'b1;
      @(posedge i_clk) i_ss_start <= 1'b0;
   endtask : start
   task automatic wait_chg;
      logic [15:0] v;
      v = o_var_even; n = 0;
      while (o_var_even === v && n < 2000) begin @(posedge i_clk); #1 n++; end
      if (n >= 2000) begin
         fail_count++;
         $display("MISMATCH %0t no variation change", $time);
         give_verdict;
      end
   endtask : wait_chg
   task automatic settle(input logic [7:0] c);
      start(c);
      repeat (1200) @(posedge i_clk);
      #1;
   endtask : settle
   task automatic t_regs;
      rd(ARSS_CFG_OFFSET, 8'h00);
      wr(ARSS_CFG_OFFSET, 8'ha5);
      rd(ARSS_CFG_OFFSET, 8'ha5);
      rd(16'h0000, 8'h00);
      $display("test regs done");
   endtask : t_regs
   task automatic t_rate;
      for (int r = 0; r < 4; r++) begin
         start({2'b10, r[1:0], 4'h8});
         wait_chg; wait_chg; wait_chg;
         chk(16'(n), PER << r);
      end
      $display("test rate done");
   endtask : t_rate
   task automatic t_var;
      settle(8'h8b); chk(o_var_odd, 16'h0030); chk(o_var_even, 16'h0030);
      settle(8'h80); chk(o_var_odd, 16'h0020); chk(o_var_even, 16'h0030);
      settle(8'h84); chk(o_var_even, 16'h0038);
      settle(8'h00); chk(o_edge[2].rise, 16'h0018); chk(o_edge[2].fall, 16'h0038);
      settle(8'h40); chk(o_edge[2].rise, 16'h0018); chk(o_edge[2].fall, 16'h0038);
      settle(8'hc0); chk(o_edge[2].rise, 16'h0010); chk(o_edge[2].fall, 16'h0030);
      $display("test variation done");
   endtask : t_var
   initial begin
      for (int i = 0; i < 8; i++) i_tgt[i] = '{16'h0010, 16'h0030};
      i_tgt[1] = '{16'h0008, 16'h0038};
      i_tgt[2] = '{16'h0010, 16'h0038};
      repeat (20) @(posedge i_clk);
      i_rst_b <= 1'b1; i_ss_active <= 1'b1;
      @(posedge i_clk);
      t_regs; t_rate; t_var;
      give_verdict;
   end
endmodule : testbench
`default_nettype wire
